// file: design/xda_map.vh
`ifndef XDA_MAP_VH
`define XDA_MAP_VH
// operation class codes
`define XDA_OP_NONE 5'h00
`define XDA_OP_MOVE 5'h01
`define XDA_OP_MOVE_SEG 5'h02
`define XDA_OP_TABLE_TRANSLATE_OP 5'h03
`define XDA_OP_LOFF 5'h04
`define XDA_OP_LFPD 5'h05
`define XDA_OP_LFPE 5'h06
`define XDA_OP_F2AH 5'h07
`define XDA_OP_AH2F 5'h08
`define XDA_OP_SEGPFX 5'h09
`define XDA_OP_ADD 5'h0A
`define XDA_OP_ADC 5'h0B
`define XDA_OP_SUB 5'h0C
`define XDA_OP_SBB 5'h0D
`define XDA_OP_CMP 5'h0E
`define XDA_OP_INC 5'h0F
`define XDA_OP_DEC 5'h10
`define XDA_OP_NEG 5'h11
`define XDA_OP_AAA 5'h12
`define XDA_OP_DAA 5'h13
`define XDA_OP_AAS 5'h14
`define XDA_OP_DAS 5'h15
`define XDA_OP_MULU 5'h16
// first-byte opcodes
`define XDA_B_MOV_RM 7'h44
`define XDA_B_MOV_MR 7'h45
`define XDA_B_MOV_TOSEG 8'h8E
`define XDA_B_MOV_FRSEG 8'h8C
`define XDA_B_TABLE_TRANSLATE_OP 8'hD7
`define XDA_B_LOFF 8'h8D
`define XDA_B_LFPD 8'hC5
`define XDA_B_LFPE 8'hC4
`define XDA_B_F2AH 8'h9F
`define XDA_B_AH2F 8'h9E
`define XDA_B_PFX_CS 8'h2E
`define XDA_B_PFX_ES 8'h26
`define XDA_B_ADD 6'h00
`define XDA_B_ADC 6'h04
`define XDA_B_SUB 6'h0A
`define XDA_B_SBB 6'h06
`define XDA_B_IMM 6'h20
`define XDA_B_IDEC 7'h7F
`define XDA_B_CMP_RM 7'h1D
`define XDA_B_CMP_MR 7'h1C
`define XDA_B_GRP3 7'h7B
`define XDA_B_INCR 5'h08
`define XDA_B_DECR 5'h09
`define XDA_B_AAA 8'h37
`define XDA_B_DAA 8'h27
`define XDA_B_AAS 8'h3F
`define XDA_B_DAS 8'h2F
// reg and mod field selectors
`define XDA_R_ADD 3'h0
`define XDA_R_ADC 3'h2
`define XDA_R_SUB 3'h5
`define XDA_R_SBB 3'h3
`define XDA_R_CMP 3'h7
`define XDA_R_INC 3'h0
`define XDA_R_DEC 3'h1
`define XDA_R_NEG 3'h3
`define XDA_R_MUL 3'h4
`define XDA_MOD_REG 2'h3
`define XDA_SEG_ES 2'h0
`define XDA_SEG_CS 2'h1
`define XDA_SEG_SS 2'h2
`define XDA_SEG_DS 2'h3
// clock counts: minimums, multiply span, address cost and handshake slack
`define XDA_C_2 7'h02
`define XDA_C_3 7'h03
`define XDA_C_4 7'h04
`define XDA_C_6 7'h06
`define XDA_C_7 7'h07
`define XDA_C_8 7'h08
`define XDA_C_9 7'h09
`define XDA_C_10 7'h0A
`define XDA_C_11 7'h0B
`define XDA_C_12 7'h0C
`define XDA_C_15 7'h0F
`define XDA_C_16 7'h10
`define XDA_C_18 7'h12
`define XDA_C_MUL_RB 7'h1A
`define XDA_C_MUL_RW 7'h23
`define XDA_C_MUL_MB 7'h20
`define XDA_C_MUL_MW 7'h29
`define XDA_C_MUL_SPAN 7'h02
`define XDA_C_EA 7'h04
`define XDA_C_HS_MAX 2'h2
`endif

// file: design/xda_decoder.v
// Notes on behaviour
// - listed clock counts are minimums; bytes are assumed present in the queue
// - wait states or bus holds stretch execution beyond the minimum
// - memory instructions may take one or two extra clocks for handshake
// - move reg to r/m 1000100w is 2/12; reverse 1000101w is 2/9
// - move into segment register 10001110, zero bit before segment field, 2/9
// - move from segment register 10001100, zero bit before segment, 2/11
// - flags to high acc byte 10011111 is 2; reverse 10011110 is 3
// - one-byte prefixes 00101110 code and 00100110 extra redirect, 2 clocks
// - add 000000dw is 3 between registers and 10 with a memory operand, whichever way d points
// - immediate group 100000sw chooses op by reg; s sign-extends byte immediate
// - subtract 001010dw and borrow 000110dw take 3 or 10
// - inc/dec 1111111w reg 000/001 take 3/15; short forms take 3
// - compare 0011101w and 0011100w update flags only, 3 or 10
// - negate 1111011w reg 011 takes 3 or 10
// - ascii add adjust 00110111 is 8; decimal add adjust 00100111 is 4
// - ascii sub adjust 00111111 is 7; decimal sub adjust 00101111 is 4
// - unsigned multiply reg 100: 26-28, 35-37, 32-34, 41-43 clocks
// - misaligned word access adds bus activity beyond the minimum
// - mod 11 makes r/m a second register selector
// - segment selector 00 extra, 01 code, 10 stack, 11 data
// - effective address costs four clocks, already in memory counts
`timescale 1ns/1ps
`include "xda_map.vh"
module xda_decoder #(
   parameter CNT_W = 7
) (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire i_ce,
   input wire i_valid,
   input wire [7:0] i_byte0,
   input wire [7:0] i_byte1,
   input wire i_bus_wait,
   input wire i_bus_hold,
   input wire i_hs_extra_1,
   input wire i_hs_extra_2,
   input wire i_addr_odd,
   output reg o_valid,
   output reg [4:0] o_op,
   output reg o_illegal,
   output reg o_word,
   output reg o_reg_dest,
   output reg o_mem,
   output reg o_two_regs,
   output reg [2:0] o_reg,
   output reg [2:0] o_rm,
   output reg [1:0] o_seg,
   output reg o_seg_override,
   output reg [1:0] o_override_seg,
   output reg o_sign_ext,
   output reg o_flags_only,
   output reg o_writes_acc_low,
   output reg o_needs_modrm,
   output reg [CNT_W-1:0] o_min_clocks,
   output reg [CNT_W-1:0] o_max_clocks,
   output reg o_busy,
   output reg o_done
);
   // pin-side stall and alignment sources cross into the clock domain first
   reg [1:0] wait_s1;
   reg [1:0] wait_s2;
   reg addr_odd_s1;
   reg addr_odd_s2;

   // picks the memory or the register count from a form's count pair
   function [CNT_W-1:0] pick;
      input is_mem;
      input [CNT_W-1:0] reg_cnt;
      input [CNT_W-1:0] mem_cnt;
      begin
         pick = is_mem ? mem_cnt : reg_cnt;
      end
   endfunction

   wire [1:0] mod_f = i_byte1[7:6];
   wire [2:0] reg_f = i_byte1[5:3];
   wire [2:0] rm_f = i_byte1[2:0];
   wire is_mem = (mod_f != `XDA_MOD_REG);

   reg [4:0] next_op;
   reg next_illegal;
   reg next_word;
   reg next_dest;
   reg next_modrm;
   reg next_flags_only;
   reg next_acc_low;
   reg next_sext;
   reg next_pfx;
   reg [1:0] next_pfx_seg;
   reg [CNT_W-1:0] next_min;
   reg [CNT_W-1:0] next_span;

   // opcode decode and minimum clock count
   always @* begin
      next_op = `XDA_OP_NONE;
      next_illegal = 1'b0;
      next_word = i_byte0[0];
      next_dest = i_byte0[1];
      next_modrm = 1'b1;
      next_flags_only = 1'b0;
      next_acc_low = 1'b0;
      next_sext = 1'b0;
      next_pfx = 1'b0;
      next_pfx_seg = `XDA_SEG_DS;
      next_min = {CNT_W{1'b0}};
      next_span = {CNT_W{1'b0}};
      if (i_byte0[7:1] == `XDA_B_MOV_RM) begin
         next_op = `XDA_OP_MOVE;
         next_dest = 1'b0;
         next_min = pick(is_mem, `XDA_C_2, `XDA_C_12);
      end else if (i_byte0[7:1] == `XDA_B_MOV_MR) begin
         next_op = `XDA_OP_MOVE;
         next_dest = 1'b1;
         next_min = pick(is_mem, `XDA_C_2, `XDA_C_9);
      end else if (i_byte0 == `XDA_B_MOV_TOSEG) begin
         next_op = `XDA_OP_MOVE_SEG;
         next_word = 1'b1;
         next_dest = 1'b1;
         next_illegal = reg_f[2];
         next_min = pick(is_mem, `XDA_C_2, `XDA_C_9);
      end else if (i_byte0 == `XDA_B_MOV_FRSEG) begin
         next_op = `XDA_OP_MOVE_SEG;
         next_word = 1'b1;
         next_dest = 1'b0;
         next_illegal = reg_f[2];
         next_min = pick(is_mem, `XDA_C_2, `XDA_C_11);
      end else if (i_byte0 == `XDA_B_TABLE_TRANSLATE_OP) begin
         next_op = `XDA_OP_TABLE_TRANSLATE_OP;
         next_modrm = 1'b0;
         next_word = 1'b0;
         next_acc_low = 1'b1;
         next_min = `XDA_C_11;
      end else if (i_byte0 == `XDA_B_LOFF) begin
         next_op = `XDA_OP_LOFF;
         next_word = 1'b1;
         next_dest = 1'b1;
         next_min = `XDA_C_6;
      end else if (i_byte0 == `XDA_B_LFPD || i_byte0 == `XDA_B_LFPE) begin
         next_op = i_byte0[0] ? `XDA_OP_LFPD : `XDA_OP_LFPE;
         next_word = 1'b1;
         next_dest = 1'b1;
         next_illegal = !is_mem;
         next_min = `XDA_C_18;
      end else if (i_byte0 == `XDA_B_F2AH) begin
         next_op = `XDA_OP_F2AH;
         next_modrm = 1'b0;
         next_min = `XDA_C_2;
      end else if (i_byte0 == `XDA_B_AH2F) begin
         next_op = `XDA_OP_AH2F;
         next_modrm = 1'b0;
         next_min = `XDA_C_3;
      end else if (i_byte0 == `XDA_B_PFX_CS || i_byte0 == `XDA_B_PFX_ES) begin
         next_op = `XDA_OP_SEGPFX;
         next_modrm = 1'b0;
         next_pfx = 1'b1;
         next_pfx_seg = i_byte0[4:3];
         next_min = `XDA_C_2;
      end else if (i_byte0[7:2] == `XDA_B_ADD || i_byte0[7:2] == `XDA_B_ADC ||
                   i_byte0[7:2] == `XDA_B_SUB || i_byte0[7:2] == `XDA_B_SBB) begin
         case (i_byte0[7:2])
            `XDA_B_ADD: next_op = `XDA_OP_ADD;
            `XDA_B_ADC: next_op = `XDA_OP_ADC;
            `XDA_B_SUB: next_op = `XDA_OP_SUB;
            default: next_op = `XDA_OP_SBB;
         endcase
         // a memory operand costs the memory count whichever way d points
         next_min = pick(is_mem, `XDA_C_3, `XDA_C_10);
      end else if (i_byte0[7:2] == `XDA_B_IMM) begin
         next_sext = i_byte0[1] & i_byte0[0];
         next_dest = 1'b0;
         next_min = pick(is_mem, `XDA_C_4, `XDA_C_16);
         case (reg_f)
            `XDA_R_ADD: next_op = `XDA_OP_ADD;
            `XDA_R_ADC: next_op = `XDA_OP_ADC;
            `XDA_R_SUB: next_op = `XDA_OP_SUB;
            `XDA_R_SBB: next_op = `XDA_OP_SBB;
            `XDA_R_CMP: begin
               next_op = `XDA_OP_CMP;
               next_flags_only = 1'b1;
               next_min = pick(is_mem, `XDA_C_3, `XDA_C_10);
            end
            default: next_illegal = 1'b1; // logic forms live in another block
         endcase
      end else if (i_byte0[7:1] == `XDA_B_IDEC) begin
         next_dest = 1'b0;
         next_min = pick(is_mem, `XDA_C_3, `XDA_C_15);
         if (reg_f == `XDA_R_INC) begin
            next_op = `XDA_OP_INC;
         end else if (reg_f == `XDA_R_DEC) begin
            next_op = `XDA_OP_DEC;
         end else begin
            next_illegal = 1'b1;
         end
      end else if (i_byte0[7:3] == `XDA_B_INCR || i_byte0[7:3] == `XDA_B_DECR) begin
         next_op = i_byte0[3] ? `XDA_OP_DEC : `XDA_OP_INC;
         next_modrm = 1'b0;
         next_word = 1'b1;
         next_min = `XDA_C_3;
      end else if (i_byte0[7:1] == `XDA_B_CMP_RM || i_byte0[7:1] == `XDA_B_CMP_MR) begin
         next_op = `XDA_OP_CMP;
         next_flags_only = 1'b1;
         next_min = pick(is_mem, `XDA_C_3, `XDA_C_10);
      end else if (i_byte0[7:1] == `XDA_B_GRP3) begin
         next_dest = 1'b0;
         if (reg_f == `XDA_R_NEG) begin
            next_op = `XDA_OP_NEG;
            next_min = pick(is_mem, `XDA_C_3, `XDA_C_10);
         end else if (reg_f == `XDA_R_MUL) begin
            next_op = `XDA_OP_MULU;
            next_span = `XDA_C_MUL_SPAN;
            if (i_byte0[0]) begin
               next_min = pick(is_mem, `XDA_C_MUL_RW, `XDA_C_MUL_MW);
            end else begin
               next_min = pick(is_mem, `XDA_C_MUL_RB, `XDA_C_MUL_MB);
            end
         end else begin
            next_illegal = 1'b1;
         end
      end else if (i_byte0 == `XDA_B_AAA) begin
         next_op = `XDA_OP_AAA;
         next_modrm = 1'b0;
         next_min = `XDA_C_8;
      end else if (i_byte0 == `XDA_B_DAA) begin
         next_op = `XDA_OP_DAA;
         next_modrm = 1'b0;
         next_min = `XDA_C_4;
      end else if (i_byte0 == `XDA_B_AAS) begin
         next_op = `XDA_OP_AAS;
         next_modrm = 1'b0;
         next_min = `XDA_C_7;
      end else if (i_byte0 == `XDA_B_DAS) begin
         next_op = `XDA_OP_DAS;
         next_modrm = 1'b0;
         next_min = `XDA_C_4;
      end else begin
         next_illegal = 1'b1;
         next_modrm = 1'b0;
      end
   end

   // upper bound of the memory handshake slack
   wire mem_acc = next_modrm && is_mem && (next_op != `XDA_OP_LOFF);
   wire [CNT_W-1:0] next_max = next_min + next_span +
                               (mem_acc ? {{(CNT_W-2){1'b0}}, `XDA_C_HS_MAX} :
                                          {CNT_W{1'b0}});

   reg [CNT_W-1:0] remain;
   reg pfx_pending;
   reg [1:0] pfx_seg;
   reg hs_more;
   reg [1:0] hs_left;

   // synchronisers: first stage feeds only the second
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wait_s1 <= 2'h0;
         wait_s2 <= 2'h0;
         addr_odd_s1 <= 1'b0;
         addr_odd_s2 <= 1'b0;
      end else if (i_ce) begin
         wait_s1 <= {i_bus_hold, i_bus_wait};
         wait_s2 <= wait_s1;
         addr_odd_s1 <= i_addr_odd;
         addr_odd_s2 <= addr_odd_s1;
      end
   end

   // stalls hold the countdown; counts never beat the published minimum
   wire stall = |wait_s2;
   // offset load has no memory cycle, so odd addresses cost it nothing
   wire misalign = addr_odd_s2 && o_word && o_mem && hs_more;
   wire accept = i_valid && !o_busy;

   // issue and execution countdown
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_valid <= 1'b0;
         o_op <= `XDA_OP_NONE;
         o_illegal <= 1'b0;
         o_word <= 1'b0;
         o_reg_dest <= 1'b0;
         o_mem <= 1'b0;
         o_two_regs <= 1'b0;
         o_reg <= 3'h0;
         o_rm <= 3'h0;
         o_seg <= `XDA_SEG_ES;
         o_seg_override <= 1'b0;
         o_override_seg <= `XDA_SEG_DS;
         o_sign_ext <= 1'b0;
         o_flags_only <= 1'b0;
         o_writes_acc_low <= 1'b0;
         o_needs_modrm <= 1'b0;
         o_min_clocks <= {CNT_W{1'b0}};
         o_max_clocks <= {CNT_W{1'b0}};
         o_busy <= 1'b0;
         o_done <= 1'b0;
         remain <= {CNT_W{1'b0}};
         pfx_pending <= 1'b0;
         pfx_seg <= `XDA_SEG_DS;
         hs_more <= 1'b0;
         hs_left <= 2'h0;
      end else if (i_ce) begin
         o_valid <= accept;
         o_done <= 1'b0;
         if (accept) begin
            o_op <= next_op;
            o_illegal <= next_illegal;
            o_word <= next_word;
            o_reg_dest <= next_dest;
            o_mem <= next_modrm && is_mem;
            o_two_regs <= next_modrm && !is_mem;
            o_reg <= reg_f;
            o_rm <= rm_f;
            o_seg <= reg_f[1:0];
            o_sign_ext <= next_sext;
            o_flags_only <= next_flags_only;
            o_writes_acc_low <= next_acc_low;
            o_needs_modrm <= next_modrm;
            o_min_clocks <= next_min;
            o_max_clocks <= next_max;
            // a prefix is consumed by the next non-prefix instruction, and overrides only if it has a memory operand
            o_seg_override <= pfx_pending && !next_pfx && next_modrm && is_mem;
            o_override_seg <= pfx_seg;
            if (next_pfx) begin
               pfx_pending <= 1'b1;
               pfx_seg <= next_pfx_seg;
            end else begin
               pfx_pending <= 1'b0;
            end
            o_busy <= 1'b1;
            remain <= next_min - {{(CNT_W-1){1'b0}}, 1'b1};
            hs_more <= mem_acc;
            hs_left <= {i_hs_extra_2, i_hs_extra_1 & ~i_hs_extra_2};
         end else if (o_busy && !stall) begin
            if (remain != {CNT_W{1'b0}}) begin
               remain <= remain - {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (misalign) begin
               o_mem <= 1'b0; // one extra bus pass for the odd half
            end else if (hs_more && hs_left != 2'h0) begin
               hs_left <= hs_left - 2'h1;
            end else begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
         end
      end
   end
endmodule

// file: verif/xda_decoder_properties.sv
`timescale 1ns/1ps
`include "xda_map.vh"
module xda_decoder_props #(
   parameter CNT_W = 7
) (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire i_ce,
   input wire i_valid,
   input wire [7:0] i_byte0,
   input wire o_valid,
   input wire [4:0] o_op,
   input wire o_word,
   input wire o_reg_dest,
   input wire o_mem,
   input wire o_two_regs,
   input wire o_flags_only,
   input wire o_writes_acc_low,
   input wire o_needs_modrm,
   input wire [CNT_W-1:0] o_min_clocks,
   input wire [CNT_W-1:0] o_max_clocks,
   input wire o_busy,
   input wire o_done
);
   wire take = i_ce && i_valid && !o_busy;
   logic [CNT_W-1:0] age;
   // cycles since the decode pulse; saturates so a long stall cannot wrap
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) age <= '0;
      else if (o_valid) age <= {{(CNT_W-1){1'b0}}, 1'h1};
      else if (~&age) age <= age + 1'h1;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   AST_TAKE: assert property (take |=> o_valid && o_busy)
      else $error("decode pulse or busy missing after accept");
   AST_MIN: assert property (o_done |-> age >= o_min_clocks)
      else $error("done came before the minimum count");
   AST_DROP: assert property ($fell(o_busy) |-> o_done)
      else $error("busy dropped without done");
   AST_MOVE: assert property (o_valid && o_op == `XDA_OP_MOVE && !o_mem |-> o_min_clocks == `XDA_C_2)
      else $error("register move count wrong");
   AST_MULU: assert property (o_valid && o_op == `XDA_OP_MULU && !o_mem |->
      o_max_clocks == o_min_clocks + `XDA_C_MUL_SPAN)
      else $error("multiply span wrong");
   AST_ADDW: assert property (take && i_byte0[7:2] == 6'h00 |=>
      o_word == $past(i_byte0[0]) && o_reg_dest == $past(i_byte0[1]))
      else $error("width or direction bit lost");
   AST_MODRM: assert property (o_valid && o_needs_modrm |-> o_two_regs != o_mem)
      else $error("register pair and memory form disagree");
   AST_PFX: assert property (take && i_byte0 == `XDA_B_PFX_CS |=>
      o_op == `XDA_OP_SEGPFX && o_min_clocks == `XDA_C_2)
      else $error("prefix decode wrong");
   AST_TABLE_TRANSLATE_OP: assert property (take && i_byte0 == `XDA_B_TABLE_TRANSLATE_OP |=>
      o_writes_acc_low && o_min_clocks == `XDA_C_11)
      else $error("translate decode wrong");
   AST_CMP: assert property (o_valid && o_op == `XDA_OP_CMP |-> o_flags_only)
      else $error("compare writes a result");
   cover property (o_done && o_op == `XDA_OP_MULU);
   cover property (o_valid && o_mem);
   cover property (take && i_byte0 == `XDA_B_PFX_CS);
endmodule
bind xda_decoder xda_decoder_props #(.CNT_W(CNT_W)) u_props (.i_clk_sys(i_clk_sys),
   .i_arst_n(i_arst_n), .i_ce(i_ce), .i_valid(i_valid), .i_byte0(i_byte0), .o_valid(o_valid),
   .o_op(o_op), .o_word(o_word), .o_reg_dest(o_reg_dest), .o_mem(o_mem),
   .o_two_regs(o_two_regs), .o_flags_only(o_flags_only), .o_writes_acc_low(o_writes_acc_low),
   .o_needs_modrm(o_needs_modrm), .o_min_clocks(o_min_clocks), .o_max_clocks(o_max_clocks),
   .o_busy(o_busy), .o_done(o_done));

// file: verif/xda_queue_model.sv
`timescale 1ns/1ps
// prefetch queue side: offers one instruction and holds it until accepted
module xda_queue_model (
   input wire logic i_clk_sys,
   input wire logic i_busy,
   output logic o_valid,
   output logic [7:0] o_byte0,
   output logic [7:0] o_byte1,
   output logic o_hs1,
   output logic o_hs2,
   output logic o_odd
);
   initial begin
      o_valid = 1'h0;
      {o_byte0, o_byte1, o_hs1, o_hs2, o_odd} = '0;
   end
   task automatic offer(input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] hs,
      input logic odd);
      int n;
      bit taken;
      // random gap so the queue is sometimes slow to refill
      repeat ($urandom_range(2, 1)) @(posedge i_clk_sys);
      #1;
      // bytes stay put until the decoder takes them
      {o_valid, o_byte0, o_byte1, o_hs2, o_hs1, o_odd} = {1'h1, b0, b1, hs, odd};
      n = 0;
      taken = 0;
      while (!taken && n < 200) begin
         @(posedge i_clk_sys);
         taken = !i_busy;
         n++;
      end
      #1;
      // released byte lines show the inverse so a stale value cannot pass; handshake lines drop to zero
      {o_valid, o_byte0, o_byte1, o_hs2, o_hs1} = {1'h0, ~b0, ~b1, 2'h0};
   endtask
endmodule

// file: verif/xda_decoder_bench.sv
`timescale 1ns/1ps
`include "xda_map.vh"
module xda_decoder_bench;
   logic i_clk_sys = 1'h0, i_arst_n = 1'h0, i_bus_wait = 1'h0, i_bus_hold = 1'h0;
   logic q_valid, q_hs1, q_hs2, q_odd;
   logic [7:0] q_b0, q_b1;
   logic o_valid, o_illegal, o_word, o_reg_dest, o_mem, o_two_regs, o_seg_override;
   logic o_sign_ext, o_flags_only, o_writes_acc_low, o_needs_modrm, o_busy, o_done;
   logic [4:0] o_op;
   logic [2:0] o_reg, o_rm;
   logic [1:0] o_seg, o_override_seg;
   logic [6:0] o_min_clocks, o_max_clocks;
   int failures = 0, tests_run = 0, cycles = 0;
   logic [11:0] tbl [40] = '{12'h888, 12'h8B8, 12'h8A8, 12'h898, 12'h8E8, 12'h8C8, 12'hD78,
      12'h8D8, 12'hC58, 12'hC48, 12'h9F8, 12'h9E8, 12'h2E8, 12'h268, 12'h008, 12'h038,
      12'h118, 12'h128, 12'h2A8, 12'h298, 12'h198, 12'h1A8, 12'h3B8, 12'h388, 12'h800,
      12'h812, 12'h835, 12'h823, 12'h817, 12'hFE0, 12'hFF1, 12'h438, 12'h4D8, 12'hF73,
      12'hF64, 12'hF74, 12'h378, 12'h278, 12'h3F8, 12'h2F8};
   always #5 i_clk_sys = ~i_clk_sys;
   xda_decoder u_xda_decoder (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(1'h1),
      .i_valid(q_valid), .i_byte0(q_b0), .i_byte1(q_b1), .i_bus_wait(i_bus_wait),
      .i_bus_hold(i_bus_hold), .i_hs_extra_1(q_hs1), .i_hs_extra_2(q_hs2), .i_addr_odd(q_odd),
      .o_valid(o_valid), .o_op(o_op), .o_illegal(o_illegal), .o_word(o_word),
      .o_reg_dest(o_reg_dest), .o_mem(o_mem), .o_two_regs(o_two_regs), .o_reg(o_reg),
      .o_rm(o_rm), .o_seg(o_seg), .o_seg_override(o_seg_override),
      .o_override_seg(o_override_seg), .o_sign_ext(o_sign_ext), .o_flags_only(o_flags_only),
      .o_writes_acc_low(o_writes_acc_low), .o_needs_modrm(o_needs_modrm),
      .o_min_clocks(o_min_clocks), .o_max_clocks(o_max_clocks), .o_busy(o_busy),
      .o_done(o_done));
   xda_queue_model u_xda_queue_model (.i_clk_sys(i_clk_sys), .i_busy(o_busy), .o_valid(q_valid),
      .o_byte0(q_b0), .o_byte1(q_b1), .o_hs1(q_hs1), .o_hs2(q_hs2), .o_odd(q_odd));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask
   // reference decode: minimum count, op class, and whether the form carries w
   function automatic int ref_min(input logic [7:0] b0, input logic [7:0] b1, output int op,
      output bit hw);
      bit m;
      m = b1[7:6] != 2'h3;
      hw = 1;
      casez (b0)
         8'b1000100?: begin op = `XDA_OP_MOVE; return m ? 12 : 2; end
         8'b1000101?: begin op = `XDA_OP_MOVE; return m ? 9 : 2; end
         8'b000000??: begin op = `XDA_OP_ADD; return m ? 10 : 3; end
         8'b000100??: begin op = `XDA_OP_ADC; return m ? 10 : 3; end
         8'b001010??: begin op = `XDA_OP_SUB; return m ? 10 : 3; end
         8'b000110??: begin op = `XDA_OP_SBB; return m ? 10 : 3; end
         8'b001110??: begin op = `XDA_OP_CMP; return m ? 10 : 3; end
         8'b100000??: begin
            op = b1[5:3] == 0 ? `XDA_OP_ADD : b1[5:3] == 2 ? `XDA_OP_ADC :
               b1[5:3] == 5 ? `XDA_OP_SUB : b1[5:3] == 3 ? `XDA_OP_SBB : `XDA_OP_CMP;
            return op == `XDA_OP_CMP ? (m ? 10 : 3) : (m ? 16 : 4);
         end
         8'b1111111?: begin op = b1[3] ? `XDA_OP_DEC : `XDA_OP_INC; return m ? 15 : 3; end
         8'b1111011?: begin
            op = b1[5:3] == 3 ? `XDA_OP_NEG : `XDA_OP_MULU;
            if (op == `XDA_OP_NEG) return m ? 10 : 3;
            return b0[0] ? (m ? 41 : 35) : (m ? 32 : 26);
         end
         default: hw = 0;
      endcase
      casez (b0)
         8'h8E: begin op = `XDA_OP_MOVE_SEG; return m ? 9 : 2; end
         8'h8C: begin op = `XDA_OP_MOVE_SEG; return m ? 11 : 2; end
         8'hD7: begin op = `XDA_OP_TABLE_TRANSLATE_OP; return 11; end
         8'h8D: begin op = `XDA_OP_LOFF; return 6; end
         8'hC5: begin op = `XDA_OP_LFPD; return 18; end
         8'hC4: begin op = `XDA_OP_LFPE; return 18; end
         8'h9F: begin op = `XDA_OP_F2AH; return 2; end
         8'h9E: begin op = `XDA_OP_AH2F; return 3; end
         8'h2E, 8'h26: begin op = `XDA_OP_SEGPFX; return 2; end
         8'b01000???: begin op = `XDA_OP_INC; return 3; end
         8'b01001???: begin op = `XDA_OP_DEC; return 3; end
         8'h37: begin op = `XDA_OP_AAA; return 8; end
         8'h27: begin op = `XDA_OP_DAA; return 4; end
         8'h3F: begin op = `XDA_OP_AAS; return 7; end
         default: begin op = `XDA_OP_DAS; return 4; end
      endcase
   endfunction
   task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] hs,
      input logic odd, input int st, input logic ill);
      int op, n, cnt, hx;
      bit hw, m;
      n = ref_min(b0, b1, op, hw);
      m = b1[7:6] != 2'h3;
      if (!hw) {hs, odd} = 3'h0;
      hx = (hw && m) ? (hs[1] ? 2 : hs[0]) : 0;
      u_xda_queue_model.offer(b0, b1, hs, odd);
      check("valid", o_valid, 1);
      check("illegal", o_illegal, ill);
      check("op", o_op, op);
      check("min", o_min_clocks, n);
      if (hw) check("word", o_word, b0[0]);
      if (hw) check("mem", o_mem, m);
      if (b0[7:6] == 2'h0 || b0[7:2] == 6'h22) check("dest", o_reg_dest, b0[1]);
      if (b0[7:2] == 6'h20) check("sext", o_sign_ext, b0[1] & b0[0]);
      // upper bound: multiply span plus the full two-clock handshake slack
      if (hw) begin
         check("max", o_max_clocks, n + 2 * m + 2 * (op == `XDA_OP_MULU));
         check("two_regs", o_two_regs, !m);
         check("reg", o_reg, b1[5:3]);
         check("rm", o_rm, b1[2:0]);
      end
      if (op == `XDA_OP_CMP) check("flags", o_flags_only, 1);
      if (op == `XDA_OP_TABLE_TRANSLATE_OP) check("acc", o_writes_acc_low, 1);
      cnt = 0;
      do begin
         @(posedge i_clk_sys);
         #1;
         cnt++;
         i_bus_wait = cnt < st;
         i_bus_hold = cnt >= st && cnt < 2 * st;
      end while (!o_done && o_busy && cnt < 300);
      check("done", o_done, 1);
      if (ill) return;
      hx += (hw && m && odd && b0[0]) ? 1 : 0;
      if (st == 0) check("latency", cnt, n + hx);
      else check("stall", cnt > n + hx, 1);
   endtask
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      logic [7:0] b0, b1;
      void'($urandom(68));
      repeat (3) @(posedge i_clk_sys);
      #1 i_arst_n = 1'h1;
      check("ovr_seg_rst", o_override_seg, 3);
      repeat (3) foreach (tbl[i]) begin
         b0 = tbl[i][11:4];
         b1 = 8'($urandom);
         if (tbl[i][3:0] < 8) b1[5:3] = tbl[i][2:0];
         if (b0 == 8'h8E || b0 == 8'h8C) b1[5] = 1'h0;
         if (b0[7:1] == 7'h62) b1[7] = 1'h0;
         run(b0, b1, 2'($urandom), 1'($urandom), 0, 0);
      end
      // every segment selector through the move into a segment register
      for (int s = 0; s < 4; s++) begin
         run(8'h8E, 8'(8'hC0 | (s << 3)), 0, 0, 0, 0);
         check("seg", o_seg, s);
      end
      run(8'hF7, 8'h26, 2'h3, 1'h1, 0, 0);
      run(8'hF7, 8'hE0, 0, 0, 6, 0);
      run(8'hC5, 8'hC0, 0, 0, 0, 1);
      run(8'h8C, 8'hE0, 0, 0, 0, 1);
      // prefix then memory operand, then a plain memory operand
      run(8'h2E, 8'h00, 0, 0, 0, 0);
      run(8'h8B, 8'h06, 0, 0, 0, 0);
      check("ovr", o_seg_override, 1);
      check("ovr_seg", o_override_seg, 1);
      run(8'h26, 8'h00, 0, 0, 0, 0);
      run(8'h89, 8'h47, 0, 0, 0, 0);
      check("ovr_seg", o_override_seg, 0);
      run(8'h8B, 8'h06, 0, 0, 0, 0);
      check("ovr", o_seg_override, 0);
      give_verdict();
   end
endmodule
